// ### pkg/rnad_pkg.sv
// rnad_pkg: constants, register map and types of the net access delay block
package rnad_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 10;                          // voice factor unit
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;   // 400000, above 4096
  localparam int IMM_MS      = 100;                         // immediate mode length
  localparam int IMM_TICKS   = IMM_MS / TICK_MS;
  localparam int STEP_MAX_MS = 10_000;                      // 10.0 sec step limit
  localparam logic [15:0] STEP_MAX_TICKS = 16'(STEP_MAX_MS / TICK_MS);

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int F_W   = 11;   // delay factor
  localparam int VF_W  = 16;   // voice factor in ticks
  localparam int CNT_W = 32;   // countdown width
  localparam int MEM_W = 8;    // active member count

  // ---------------------------------------------------------------
  // register indices (word addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;  // [0] enable, [2:1] scheme
  localparam logic [3:0] REG_PRIO   = 4'h1;  // [7:0] station, [15:8] message, [23:16] index
  localparam logic [3:0] REG_HYB    = 4'h2;  // [10:0] lower, [26:16] upper
  localparam logic [3:0] REG_VLIM   = 4'h3;  // [15:0] minimum, [31:16] maximum
  localparam logic [3:0] REG_VSTEP  = 4'h4;  // [15:0] increment, [31:16] decrement
  localparam logic [3:0] REG_TIMES  = 4'h5;  // [15:0] busy detect, [31:16] turnaround
  localparam logic [3:0] REG_TP     = 4'h6;  // post reception timer, cycles
  localparam logic [3:0] REG_STATUS = 4'h7;  // read only
  localparam logic [3:0] REG_FACTOR = 4'h8;  // read only
  localparam logic [3:0] REG_SCHED  = 4'h9;  // read only

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_PRIO  = 32'h0000_0000;
  localparam logic [31:0] RST_HYB   = 32'h0000_0000;
  localparam logic [31:0] RST_VLIM  = 32'h0064_0000;
  localparam logic [31:0] RST_VSTEP = 32'h0001_000a;
  localparam logic [31:0] RST_TIMES = 32'h0010_0010;
  localparam logic [31:0] RST_TP    = 32'h0000_0100;
  localparam logic [1:0]  PREC_NONE = 2'h3;   // empty frame group

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SCH_PRIO, SCH_HYBRID, SCH_RADIO, SCH_DETERM
  } rnad_scheme_t;

  typedef enum logic [1:0] {
    ST_OFF, ST_WAIT_TP, ST_COUNT
  } rnad_state_t;

endpackage : rnad_pkg

// ### rtl/rnad_down_counter.sv
// rnad_down_counter: loadable down counter with step enable, abort and expiry pulse
module rnad_down_counter
  import rnad_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic         step,
  input  wire logic         abort,
  output logic              busy,
  output logic              expire
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // abort beats load so that traffic always stops a running interval
  always_comb begin
    count_d = count_q;
    if (abort) begin
      count_d = '0;
    end else if (load) begin
      count_d = load_value;
    end else if (step && count_q != '0) begin
      count_d = count_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign busy   = (count_q != '0);
  assign expire = step && (count_q == W'(1)) && !abort && !load;

endmodule // rnad_down_counter

// ### rtl/rnad_lfsr.sv
// rnad_lfsr: free running pseudorandom source for the random fraction
module rnad_lfsr
  import rnad_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  output logic      [7:0] random_fraction
);

  logic [15:0] lfsr_q;
  logic [15:0] lfsr_d;

  // galois form, taps 16,14,13,11; never reaches the all zero lock-up state
  always_comb begin
    lfsr_d = {1'b0, lfsr_q[15:1]};
    if (lfsr_q[0]) begin
      lfsr_d = lfsr_d ^ 16'hb400;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lfsr_q <= 16'hace1;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign random_fraction = lfsr_q[7:0];

endmodule // rnad_lfsr

// ### rtl/rnad_top.sv
// rnad_top: channel access delay engine for a station on a shared radio data net
//
// Notes on behaviour
// - prioritized scheme: factor is station, message and index terms summed.
// - hybrid scheme: factor is lower bound plus random fraction times bound span.
// - radio embedded: higher precedence frame ready rebuilds the pending frame group.
// - voice factor starts at its minimum when the radio embedded scheme starts.
// - voice detection raises the voice factor by the increment step, 0 to 10 s; at most one deferred step waits per expiry.
// - voice factor at minimum: increment applies at once and restarts the scheduler.
// - voice factor above minimum: increment waits for the next scheduler expiry.
// - each access delay expiry lowers the voice factor by the decrement step.
// - active member count follows the transmitters heard on the net.
// - scheduler interval is recomputed after each own transmission.
// - traffic during the short immediate mode aborts it and clears its flag.
// - a precedence change marks the new transmission with the new level.
// - deterministic scheme: first station number sent is last received plus one.
// - outside radio embedded, delay is factor times busy detect plus max(0, factor-1) times turnaround.
// - while the post reception timer runs, the access delay countdown waits.
//
// The address map and strobed register access were chosen for this implementation.
module rnad_top
  import rnad_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  wire logic             rx_frame_done,
  input  wire logic [7:0]       rx_first_station,
  input  wire logic             voice_detect,
  input  wire logic             data_detect,
  input  wire logic             member_heard,
  input  wire logic             member_lost,
  input  wire logic             frame_pending,
  input  wire logic             frame_ready,
  input  wire logic [1:0]       frame_precedence,
  input  wire logic [1:0]       msg_precedence,
  input  wire logic             tx_done,
  input  wire logic             imm_start,
  output logic                  access_grant,
  output logic                  access_expire,
  output logic                  group_rebuild_q,
  output logic      [1:0]       tx_precedence_q,
  output logic                  precedence_mark_q,
  output logic      [7:0]       tx_first_station_q,
  output logic                  imm_active
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q, prio_q, hyb_q, vlim_q, vstep_q, times_q, tp_q;
  logic [31:0] ctrl_d, prio_d, hyb_d, vlim_d, vstep_d, times_d, tp_d;
  logic [31:0] rdata_d;
  logic [31:0] status_w;

  rnad_scheme_t scheme;
  logic         enable;
  logic [VF_W-1:0] vmin, vmax, vinc, vdec;

  assign enable = ctrl_q[0];
  assign scheme = rnad_scheme_t'(ctrl_q[2:1]);
  assign vmin   = vlim_q[15:0];
  assign vmax   = vlim_q[31:16];
  assign vinc   = vstep_q[15:0];
  assign vdec   = vstep_q[31:16];

  // step writes are clamped to the 10 s limit rather than refused
  always_comb begin
    ctrl_d  = ctrl_q;
    prio_d  = prio_q;
    hyb_d   = hyb_q;
    vlim_d  = vlim_q;
    vstep_d = vstep_q;
    times_d = times_q;
    tp_d    = tp_q;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL:  ctrl_d  = {29'h0, reg_wdata[2:0]};
        REG_PRIO:  prio_d  = {8'h0, reg_wdata[23:0]};
        REG_HYB:   hyb_d   = {5'h0, reg_wdata[26:16], 5'h0, reg_wdata[10:0]};
        REG_VLIM:  vlim_d  = reg_wdata;
        REG_VSTEP: vstep_d = {(reg_wdata[31:16] > STEP_MAX_TICKS) ? STEP_MAX_TICKS : reg_wdata[31:16],
                              (reg_wdata[15:0] > STEP_MAX_TICKS) ? STEP_MAX_TICKS : reg_wdata[15:0]};
        REG_TIMES: times_d = reg_wdata;
        REG_TP:    tp_d    = reg_wdata;
        default:   ctrl_d  = ctrl_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // engine state
  // ---------------------------------------------------------------
  rnad_state_t     st_q, st_d;
  logic [VF_W-1:0] vf_q, vf_d;
  logic            pend_inc_q, pend_inc_d;
  logic [MEM_W-1:0] members_q, members_d;
  logic [VF_W-1:0] sched_q, sched_d;
  logic [F_W-1:0]  factor_q, factor_d;
  logic [1:0]      group_prec_q, group_prec_d;
  logic            rebuild_d;
  logic [1:0]      tx_prec_d;
  logic            prec_mark_d;
  logic [7:0]      first_stn_d;

  logic            tick, tp_busy, dly_busy, dly_expire;
  logic            load_delay, dly_abort, radio;
  logic [7:0]      rnd;
  logic [F_W-1:0]  f_prio, f_hyb, f_val, f_span;
  logic [18:0]     f_prod;
  logic [27:0]     nad_cycles;
  logic [CNT_W-1:0] dly_value;
  logic [VF_W-1:0] vf_up, vf_after, vf_down;
  logic [VF_W+MEM_W-1:0] sched_prod;

  assign radio = (scheme == SCH_RADIO);

  // saturating voice factor arithmetic, never wraps past the limits
  function automatic logic [VF_W-1:0] sat_add(input logic [VF_W-1:0] a, input logic [VF_W-1:0] b,
                                              input logic [VF_W-1:0] hi);
    logic [VF_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, hi}) ? hi : s[VF_W-1:0];
  endfunction

  function automatic logic [VF_W-1:0] sat_sub(input logic [VF_W-1:0] a, input logic [VF_W-1:0] b,
                                              input logic [VF_W-1:0] lo);
    sat_sub = (a < b || (a - b) < lo) ? lo : a - b;
  endfunction

  // ---------------------------------------------------------------
  // delay factor and delay length
  // ---------------------------------------------------------------
  always_comb begin
    f_prio = F_W'(prio_q[7:0]) + F_W'(prio_q[15:8]) + F_W'(prio_q[23:16]);
    f_span = (hyb_q[26:16] > hyb_q[10:0]) ? hyb_q[26:16] - hyb_q[10:0] : '0;
    f_prod = {8'h0, f_span} * {11'h0, rnd};
    f_hyb  = hyb_q[10:0] + f_prod[18:8];                     // truncated
    unique case (scheme)
      SCH_PRIO:   f_val = f_prio;
      SCH_HYBRID: f_val = f_hyb;
      SCH_RADIO:  f_val = F_W'(sched_q[10:0]);
      SCH_DETERM: f_val = F_W'(prio_q[23:16]);
    endcase
    nad_cycles = 28'(f_val * times_q[15:0])
               + ((f_val == '0) ? 28'h0 : 28'((f_val - F_W'(1)) * times_q[31:16]));
    // radio embedded counts scheduler ticks instead of cycles
    dly_value  = radio ? CNT_W'(sched_q) : CNT_W'(nad_cycles);
    sched_prod = {{MEM_W{1'b0}}, vf_q} + VF_W'((rnd * members_q) >> 8);
  end

  // ---------------------------------------------------------------
  // voice factor next value
  // ---------------------------------------------------------------
  always_comb begin
    vf_up    = sat_add(vf_q, vinc, vmax);
    vf_after = pend_inc_q ? vf_up : vf_q;                    // deferred increment lands here
    vf_down  = sat_sub(vf_after, vdec, vmin);
  end

  // ---------------------------------------------------------------
  // control sequence
  // ---------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    vf_d         = vf_q;
    pend_inc_d   = pend_inc_q;
    sched_d      = sched_q;
    factor_d     = factor_q;
    load_delay   = 1'b0;
    dly_abort    = 1'b0;
    group_prec_d = group_prec_q;
    rebuild_d    = 1'b0;
    tx_prec_d    = tx_precedence_q;
    prec_mark_d  = 1'b0;
    first_stn_d  = tx_first_station_q;
    members_d    = members_q;
    // member table follows what is heard on the net
    if (member_heard && !member_lost && members_q != '1) begin
      members_d = members_q + MEM_W'(1);
    end else if (member_lost && !member_heard && members_q != '0) begin
      members_d = members_q - MEM_W'(1);
    end
    unique case (st_q)
      ST_OFF: begin
        dly_abort = 1'b1;
        if (enable) begin
          vf_d       = vmin;
          pend_inc_d = 1'b0;
          sched_d    = vmin;
          st_d       = ST_WAIT_TP;
        end
      end
      ST_WAIT_TP: begin
        if (!tp_busy && !rx_frame_done) begin
          load_delay = 1'b1;
          factor_d   = f_val;
          st_d       = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (dly_expire) begin
          st_d = ST_WAIT_TP;                                 // fresh delay after every expiry
          if (radio) begin
            vf_d       = vf_down;
            pend_inc_d = 1'b0;
          end
        end
        if (rx_frame_done || tx_done) begin
          dly_abort = 1'b1;
          st_d      = ST_WAIT_TP;
        end
      end
      default: st_d = ST_OFF;
    endcase
    // voice hits only shape the scheduler while the radio scheme runs
    if (radio && st_q != ST_OFF && voice_detect) begin
      if (vf_q == vmin) begin
        vf_d      = vf_up;
        dly_abort = 1'b1;
        st_d      = ST_WAIT_TP;
      end else begin
        pend_inc_d = 1'b1;                                   // set wins over expiry clear
      end
    end
    if (tx_done) begin
      sched_d      = sched_prod[VF_W-1:0];
      group_prec_d = PREC_NONE;
    end
    if (radio && frame_ready && frame_precedence < group_prec_d) begin
      rebuild_d    = 1'b1;
      group_prec_d = frame_precedence;
    end
    if (access_grant && msg_precedence != tx_precedence_q) begin
      tx_prec_d   = msg_precedence;
      prec_mark_d = 1'b1;
    end
    if (scheme == SCH_DETERM && rx_frame_done) begin
      first_stn_d = rx_first_station + 8'h01;
    end
    if (!enable) begin
      st_d = ST_OFF;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q             <= RST_CTRL;
      prio_q             <= RST_PRIO;
      hyb_q              <= RST_HYB;
      vlim_q             <= RST_VLIM;
      vstep_q            <= RST_VSTEP;
      times_q            <= RST_TIMES;
      tp_q               <= RST_TP;
      reg_rdata          <= '0;
      st_q               <= ST_OFF;
      vf_q               <= '0;
      pend_inc_q         <= 1'b0;
      sched_q            <= '0;
      factor_q           <= '0;
      members_q          <= '0;
      group_prec_q       <= PREC_NONE;
      group_rebuild_q    <= 1'b0;
      tx_precedence_q    <= PREC_NONE;
      precedence_mark_q  <= 1'b0;
      tx_first_station_q <= '0;
    end else begin
      ctrl_q             <= ctrl_d;
      prio_q             <= prio_d;
      hyb_q              <= hyb_d;
      vlim_q             <= vlim_d;
      vstep_q            <= vstep_d;
      times_q            <= times_d;
      tp_q               <= tp_d;
      reg_rdata          <= rdata_d;
      st_q               <= st_d;
      vf_q               <= vf_d;
      pend_inc_q         <= pend_inc_d;
      sched_q            <= sched_d;
      factor_q           <= factor_d;
      members_q          <= members_d;
      group_prec_q       <= group_prec_d;
      group_rebuild_q    <= rebuild_d;
      tx_precedence_q    <= tx_prec_d;
      precedence_mark_q  <= prec_mark_d;
      tx_first_station_q <= first_stn_d;
    end
  end

  // ---------------------------------------------------------------
  // read port, data valid one cycle after the strobe
  // ---------------------------------------------------------------
  assign status_w = {3'h0, tx_precedence_q, st_q, imm_active, members_q, vf_q};

  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   rdata_d = ctrl_q;
        REG_PRIO:   rdata_d = prio_q;
        REG_HYB:    rdata_d = hyb_q;
        REG_VLIM:   rdata_d = vlim_q;
        REG_VSTEP:  rdata_d = vstep_q;
        REG_TIMES:  rdata_d = times_q;
        REG_TP:     rdata_d = tp_q;
        REG_STATUS: rdata_d = status_w;
        REG_FACTOR: rdata_d = {21'h0, factor_q};
        REG_SCHED:  rdata_d = {16'h0, sched_q};
        default:    rdata_d = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // timers and random source
  // ---------------------------------------------------------------
  logic tick_busy;

  // tick divider reloads from idle only: feeding expire back into load would loop through its gating
  rnad_down_counter #(.W(CNT_W)) u_tick (
    .clk_sys(clk_sys), .reset(reset), .load(!tick_busy), .load_value(CNT_W'(TICK_LEN - 1)),
    .step(1'b1), .abort(1'b0), .busy(tick_busy), .expire(tick));

  rnad_down_counter #(.W(CNT_W)) u_tp (
    .clk_sys(clk_sys), .reset(reset), .load(rx_frame_done), .load_value(tp_q),
    .step(1'b1), .abort(!enable), .busy(tp_busy), .expire());

  rnad_down_counter #(.W(CNT_W)) u_delay (
    .clk_sys(clk_sys), .reset(reset), .load(load_delay), .load_value(dly_value),
    .step(radio ? tick : 1'b1), .abort(dly_abort), .busy(dly_busy), .expire(dly_expire));

  // any traffic seen ends the short immediate mode at once
  rnad_down_counter #(.W(CNT_W)) u_imm (
    .clk_sys(clk_sys), .reset(reset), .load(radio && imm_start), .load_value(CNT_W'(IMM_TICKS)),
    .step(tick), .abort(voice_detect || data_detect || !enable), .busy(imm_active), .expire());

  rnad_lfsr u_random_fraction (.clk_sys(clk_sys), .reset(reset), .random_fraction(rnd));

  assign access_expire = dly_expire && (st_q == ST_COUNT);
  assign access_grant  = access_expire && frame_pending;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_wait_then_load;
    (st_q == ST_WAIT_TP && !tp_busy && !rx_frame_done && enable) ##1 (st_q == ST_COUNT && dly_busy);
  endsequence

  a_prio_factor: assert property ((load_delay && scheme == SCH_PRIO && enable) |=> factor_q ==
    $past(F_W'(prio_q[7:0]) + F_W'(prio_q[15:8]) + F_W'(prio_q[23:16]))) else $error("prio factor");
  a_hyb_bounds: assert property ((load_delay && scheme == SCH_HYBRID && hyb_q[26:16] >= hyb_q[10:0])
    |=> factor_q >= hyb_q[10:0] && factor_q <= hyb_q[26:16]) else $error("hybrid factor out of range");
  a_group_rebuild: assert property ((radio && frame_ready && frame_precedence < group_prec_q && !tx_done)
    |=> group_rebuild_q && group_prec_q == $past(frame_precedence)) else $error("no rebuild");
  a_voice_start: assert property ((st_q == ST_OFF && enable) |=> vf_q == vmin && !pend_inc_q)
    else $error("voice factor not at minimum");
  a_fast_attack: assert property ((radio && st_q != ST_OFF && enable && voice_detect && vf_q == vmin
    && !reg_wr) |=> vf_q == sat_add($past(vf_q), vinc, vmax) && st_q == ST_WAIT_TP) else $error("no fast attack");
  a_defer_inc: assert property ((radio && st_q != ST_OFF && enable && voice_detect && vf_q > vmin)
    |=> pend_inc_q) else $error("increment not deferred");
  a_slow_decay: assert property ((access_expire && radio && !pend_inc_q && !voice_detect && enable
    && !reg_wr) |=> vf_q == sat_sub($past(vf_q), vdec, vmin)) else $error("no decay");
  a_vf_limits: assert property ((st_q != ST_OFF && vmin <= vmax && !$changed(vlim_q)) |->
    vf_q >= vmin && vf_q <= vmax) else $error("voice factor outside limits");
  a_member_up: assert property ((member_heard && !member_lost && members_q != '1)
    |=> members_q == $past(members_q) + MEM_W'(1)) else $error("member count");
  a_imm_abort: assert property ((imm_active && (voice_detect || data_detect)) |=> !imm_active)
    else $error("immediate mode not aborted");
  a_prec_mark: assert property ((access_grant && msg_precedence != tx_precedence_q)
    |=> precedence_mark_q && tx_precedence_q == $past(msg_precedence)) else $error("precedence");
  a_first_stn: assert property ((scheme == SCH_DETERM && rx_frame_done)
    |=> tx_first_station_q == $past(rx_first_station) + 8'h01) else $error("first station");
  a_tp_holds: assert property ((tp_busy && st_q == ST_WAIT_TP) |=> !dly_busy) else $error("delay ran in tp");
  a_delay_load: assert property (s_wait_then_load |-> radio || factor_q == $past(f_val, 1))
    else $error("delay load");

endmodule // rnad_top

// ### tb/rnad_net_peer.sv
// rnad_net_peer: model of the other stations heard on the shared radio net
module rnad_net_peer (
  input  wire logic       clk_sys,
  output logic            rx_frame_done,
  output logic      [7:0] rx_first_station,
  output logic            voice_detect,
  output logic            data_detect,
  output logic            member_heard,
  output logic            member_lost
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet net at time zero
  initial {rx_frame_done, voice_detect, data_detect, member_heard, member_lost} = 5'h00;
  initial rx_first_station = 8'h5a;
  // one-cycle event burst: mask is frame, voice, data, heard, lost
  task automatic send(input logic [4:0] m, input logic [7:0] s);
    @(posedge clk_sys);
    {rx_frame_done, voice_detect, data_detect, member_heard, member_lost} <= m;
    rx_first_station <= s;
    @(posedge clk_sys);
    {rx_frame_done, voice_detect, data_detect, member_heard, member_lost} <= 5'h00;
    rx_first_station <= ~s;  // stale number must not look valid
  endtask
endmodule // rnad_net_peer

// ### tb/tb.sv
// tb: self-checking bench for the net access delay engine
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rnad_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, p;
  logic frame_ready = 1'b0, imm_start = 1'b0, group_rebuild_q, imm_active, access_expire;
  logic frame_pending = 1'b0, tx_done = 1'b0, access_grant, precedence_mark_q;
  logic [1:0] frame_precedence = 2'h3, msg_precedence = 2'h0, tx_precedence_q;
  logic [7:0] tx_first_station_q, rx_first_station, s;
  logic rx_frame_done, voice_detect, data_detect, member_heard, member_lost;
  logic [63:0] notes [$], nt;
  int n_mismatch = 0, compares = 0, seed = 61, k;
  always #12.5 clk_sys = ~clk_sys;
  rnad_top #(.TICK_LEN(4)) rnad_top_i (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_frame_done, .rx_first_station, .voice_detect, .data_detect, .member_heard,
    .member_lost, .frame_pending, .frame_ready, .frame_precedence, .msg_precedence,
    .tx_done, .imm_start, .access_grant, .access_expire, .group_rebuild_q,
    .tx_precedence_q, .precedence_mark_q, .tx_first_station_q, .imm_active);
  rnad_net_peer rnad_net_peer_i (.clk_sys, .rx_frame_done, .rx_first_station, .voice_detect,
    .data_detect, .member_heard, .member_lost);
  // ---------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read note holds field mask and expected value
  task automatic rd(input logic [3:0] a, input logic [31:0] m, e);
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b1, a};
    notes.push_back({m, e});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // read data stands only in the cycle after its strobe
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      nt = notes.pop_front();
      chk(reg_rdata & nt[63:32], nt[31:0]);
    end
  end
  task automatic results();
    if (notes.size() != 0) n_mismatch++;  // a read answer never came
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(REG_VLIM, '1, RST_VLIM);
    rd(REG_VSTEP, '1, RST_VSTEP);
    rd(REG_TIMES, '1, RST_TIMES);
    rd(REG_TP, '1, RST_TP);
    rd(4'hf, '1, 32'h0);
    // busy 2, turnaround 1: delay is 3F-1 counts; index term kept odd so F>0
    wr(REG_TIMES, 32'h0001_0002);
    repeat (3) begin
      p = ($random(seed) & 32'h003f_3f3f) | 32'h0001_0000;
      wr(REG_PRIO, p);
      wr(REG_CTRL, 32'h1);
      frame_pending <= 1'b1;
      msg_precedence <= msg_precedence + 2'h1;  // every round brings a new precedence
      k = 0;
      while (access_expire !== 1'b1 && k < 900) begin
        @(negedge clk_sys);
        k++;
      end
      if (k >= 900) begin
        n_mismatch++;
        results();
      end
      chk(32'(k), 3 * (p[7:0] + p[15:8] + p[23:16]) + 1);
      chk(access_grant, 1'b1);
      @(posedge clk_sys) #1 chk({tx_precedence_q, precedence_mark_q}, {msg_precedence, 1'b1});
      rd(REG_FACTOR, 32'h7ff, p[7:0] + p[15:8] + p[23:16]);
      wr(REG_CTRL, 32'h0);
    end
    // equal bounds leave no room for the random fraction
    p = $random(seed) & 32'h7ff;
    wr(REG_HYB, {5'h0, p[10:0], 5'h0, p[10:0]});
    wr(REG_CTRL, 32'h3);
    repeat (4) @(posedge clk_sys);
    rd(REG_FACTOR, 32'h7ff, p);
    wr(REG_CTRL, 32'h0);  // limits change only while stopped
    wr(REG_VLIM, 32'h0014_0002);
    for (int i = 0; i < 2; i++) begin
      wr(REG_CTRL, 32'h0);
      wr(REG_VSTEP, i ? 32'h0001_001e : 32'h0001_0005);
      wr(REG_CTRL, 32'h5);
      rd(REG_STATUS, 32'hffff, 32'h2);
      rnad_net_peer_i.send(5'h08, 8'h0);
      rd(REG_STATUS, 32'hffff, i ? 32'h14 : 32'h7);
      @(posedge clk_sys) tx_done <= 1'b1;
      @(posedge clk_sys) tx_done <= 1'b0;
      rd(REG_SCHED, 32'hffff, i ? 32'h14 : 32'h7); // no members heard yet
      rnad_net_peer_i.send(5'h08, 8'h0);  // voice above minimum defers its step
    end
    repeat (3) rnad_net_peer_i.send(5'h02, 8'h0);
    rnad_net_peer_i.send(5'h01, 8'h0);
    rnad_net_peer_i.send(5'h03, 8'h0);
    rd(REG_STATUS, 32'h00ff_0000, 32'h0002_0000);
    @(posedge clk_sys) imm_start <= 1'b1;
    @(posedge clk_sys) imm_start <= 1'b0;
    #1 chk(imm_active, 1'b1);
    rnad_net_peer_i.send(5'h04, 8'h0);
    #1 chk(imm_active, 1'b0);
    // an urgent frame rebuilds the group once, a second of equal rank does not
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys) {frame_ready, frame_precedence} <= 3'h4;
      @(posedge clk_sys) frame_ready <= 1'b0;
      #1 chk(group_rebuild_q, i == 0);
    end
    wr(REG_CTRL, 32'h7);
    for (int i = 0; i < 2; i++) begin
      s = i ? 8'hff : 8'($random(seed));
      rnad_net_peer_i.send(5'h10, s);
      #1 chk(tx_first_station_q, 8'(s + 8'h1));
    end
    repeat (3) @(posedge clk_sys);
    results();
  end
endmodule // tb
